// [ccss_pkg.sv]
// Package for the charger configuration source selector.
// Assumes a single 25 MHz clock; values are codes, not physical units.
package ccss_pkg;
  // Input current limit codes, in mA where fixed
  localparam logic [11:0] CCSS_INPUT_LIMIT_RESISTOR_PIN_100_MA  = 12'h064;
  localparam logic [11:0] CCSS_INPUT_LIMIT_RESISTOR_PIN_150_MA  = 12'h096;
  localparam logic [11:0] CCSS_INPUT_LIMIT_RESISTOR_PIN_500_MA  = 12'h1F4;
  localparam logic [11:0] CCSS_INPUT_LIMIT_RESISTOR_PIN_900_MA  = 12'h384;
  localparam logic [11:0] CCSS_INPUT_LIMIT_RESISTOR_PIN_2000_MA = 12'h7D0;
  localparam logic [11:0] CCSS_INPUT_LIMIT_RESISTOR_PIN_ZERO    = 12'h000;
  // Input voltage floor in 10 mV units
  localparam logic [9:0]  CCSS_FLOOR_436    = 10'h1B4;
  localparam logic [9:0]  CCSS_FLOOR_468    = 10'h1D4;
  localparam logic [9:0]  CCSS_FLOOR_NONE   = 10'h000;
  // Register map, byte addresses
  localparam logic [7:0]  CCSS_ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  CCSS_ADDR_INPUT_LIMIT_RESISTOR_PIN    = 8'h04;
  localparam logic [7:0]  CCSS_ADDR_ICHG    = 8'h08;
  localparam logic [7:0]  CCSS_ADDR_STATUS  = 8'h0C;
  localparam logic [7:0]  CCSS_ADDR_IRQ     = 8'h10;
  localparam logic [7:0]  CCSS_ADDR_MASK    = 8'h14;
  // Control field positions
  localparam int CCSS_CTRL_WDOG_EN  = 0;
  localparam int CCSS_CTRL_KICK     = 1;
  // Interrupt bit positions
  localparam int CCSS_IRQ_WDOG      = 0;
  localparam int CCSS_IRQ_FAULT     = 1;
  localparam int CCSS_IRQ_PHASE     = 2;
  localparam int CCSS_IRQ_W         = 3;
  // Watchdog period
  localparam longint CCSS_CLK_HZ    = 25000000;
  localparam longint CCSS_WDOG_S    = 50;
  localparam longint CCSS_WDOG_CYC  = CCSS_WDOG_S * CCSS_CLK_HZ;
  // Mode and charge phase types
  typedef enum logic {CCSS_STANDALONE, CCSS_HOST} ccss_mode_type;
  typedef enum logic [2:0] {CCSS_IDLE, CCSS_TRICKLE, CCSS_PRE, CCSS_CC,
                            CCSS_CV, CCSS_DONE} ccss_phase_type;
endpackage

// [ccss_pin_decode.sv]
// Select pin decoder: input current limit and input voltage floor.
// Assumes the select pins are already synchronous to sys_clk.
`timescale 1ns/1ps
module ccss_pin_decode
(
  // Pins
  input  wire logic        limit_select_bit0,
  input  wire logic        limit_select_bit1,
  input  wire logic        limit_select_bit2,
  // Resistor-set values
  input  wire logic [11:0] ext_input_limit_resistor_pin,
  input  wire logic [9:0]  ext_floor,
  // Result
  output logic [11:0]      pin_input_limit_resistor_pin,
  output logic [9:0]       pin_floor,
  output logic             pin_hiz,
  output logic             usb3_profile
);
  import ccss_pkg::*;
  wire logic [1:0] low_sel;
  wire logic       fixed_code;
  assign low_sel = {limit_select_bit1, limit_select_bit0};
  // Highest pin picks the current set                       [R10]
  assign usb3_profile = limit_select_bit2;
  assign pin_hiz    = (low_sel == 2'h3);
  assign fixed_code = !low_sel[0];
  // Limit table                                            [R7] [R8]
  assign pin_input_limit_resistor_pin = (low_sel == 2'h1) ? ext_input_limit_resistor_pin :
                    (low_sel == 2'h3) ? CCSS_INPUT_LIMIT_RESISTOR_PIN_ZERO :
                    (low_sel == 2'h0) ?
                      (usb3_profile ? CCSS_INPUT_LIMIT_RESISTOR_PIN_900_MA : CCSS_INPUT_LIMIT_RESISTOR_PIN_500_MA) :
                      (usb3_profile ? CCSS_INPUT_LIMIT_RESISTOR_PIN_150_MA : CCSS_INPUT_LIMIT_RESISTOR_PIN_100_MA);
  // Floor follows the code                                 [R9]
  assign pin_floor = fixed_code ? CCSS_FLOOR_436 :
                     pin_hiz    ? CCSS_FLOOR_NONE : ext_floor;
endmodule

// [ccss_phase_seq.sv]
// Charge phase sequencer: trickle, pre-charge, constant current, voltage.
// Assumes threshold flags come from the analog front end, synchronous.
`timescale 1ns/1ps
module ccss_phase_seq
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  // Conditions
  input  wire logic          charge_ok,
  input  wire logic          above_trickle,
  input  wire logic          above_pre,
  input  wire logic          at_regulation,
  input  wire logic          taper_done,
  // Phase
  output ccss_pkg::ccss_phase_type phase,
  output logic               phase_change
);
  import ccss_pkg::*;
  ccss_phase_type phase_ff;
  ccss_phase_type nxt_phase;
  // Strictly sequential phases; a suspend returns to idle     [R15]
  always_comb
  begin
    nxt_phase = phase_ff;
    if (!charge_ok)
      nxt_phase = CCSS_IDLE;
    else
      case (phase_ff)
        CCSS_IDLE:    nxt_phase = CCSS_TRICKLE;
        CCSS_TRICKLE: if (above_trickle) nxt_phase = CCSS_PRE;
        CCSS_PRE:     if (above_pre) nxt_phase = CCSS_CC;
        CCSS_CC:      if (at_regulation) nxt_phase = CCSS_CV;
        CCSS_CV:      if (taper_done) nxt_phase = CCSS_DONE;
        CCSS_DONE:    nxt_phase = CCSS_DONE;
        default:      nxt_phase = CCSS_IDLE;
      endcase
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      phase_ff <= CCSS_IDLE;
    else
      phase_ff <= nxt_phase;
  end
  assign phase        = phase_ff;
  assign phase_change = (nxt_phase != phase_ff);
endmodule

// [ccss_top.sv]
// Configuration source selector for a single-cell charger.
// Assumes a synchronous register port driven by the serial-bus bridge.
//
// Summary of operation
// R1: Host mode uses registers, status readable
// R2: Standalone uses resistor-sensed limits
// R3: Dedicated charging adapter forces standalone defaults
// R4: Host mode only while accessed, watchdog alive
// R5: Watchdog expiry returns to standalone
// R6: On power good, pick source by command
// R7: Low profile: 500, resistor, 100, high-Z
// R8: High profile: 900, resistor, 150, high-Z
// R9: Floor follows select pins
// R10: Highest select pin picks USB profile
// R11: No-pin variant uses port detection limit
// R12: Without detection host may program limit
// R13: Shorted input limit resistor gives 2 A
// R14: Shorted charge resistor faults, suspends charge
// R15: Four charge phases in order
// R16: Reset into standalone, decision registered
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module ccss_top
#(
  parameter longint WDOG_CYCLES = ccss_pkg::CCSS_WDOG_CYC,
  parameter bit     HAS_PINS    = 1'b1
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  // Select pins
  input  wire logic        limit_select_bit0,
  input  wire logic        limit_select_bit1,
  input  wire logic        limit_select_bit2,
  // Resistor sense results
  input  wire logic [11:0] input_limit_resistor_pin,
  input  wire logic        input_limit_shorted,
  input  wire logic [11:0] charge_current_resistor_pin,
  input  wire logic        charge_current_shorted,
  input  wire logic [9:0]  input_floor_resistor_pin,
  input  wire logic        input_floor_shorted,
  // Environment
  input  wire logic        power_good,
  input  wire logic        dcp_present,
  input  wire logic        dpdm_used,
  input  wire logic [11:0] port_detect_input_limit_resistor_pin,
  input  wire logic        above_trickle,
  input  wire logic        above_pre,
  input  wire logic        at_regulation,
  input  wire logic        taper_done,
  // Results
  output logic [11:0]      input_limit,
  output logic [11:0]      charge_limit,
  output logic [9:0]       input_voltage_floor,
  output logic             input_hiz,
  output logic             usb3_profile,
  output logic             host_mode,
  output logic             charge_fault,
  output ccss_pkg::ccss_phase_type charge_phase,
  output logic             irq
);
  import ccss_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [1:0]           ctrl_ff;
  logic [11:0]          host_input_limit_resistor_pin_ff;
  logic [11:0]          host_ichg_ff;
  logic [CCSS_IRQ_W-1:0] irq_ff;
  logic [CCSS_IRQ_W-1:0] mask_ff;
  logic [31:0]          rdata_ff;
  logic [31:0]          wdog_ff;
  logic                 cmd_seen_ff;
  logic                 pg_ff;
  logic                 fault_ff;
  ccss_mode_type        mode_ff;
  ccss_mode_type        nxt_mode;

  // Decode
  wire logic wr_ctrl   = reg_write && (reg_addr == CCSS_ADDR_CTRL);
  wire logic wr_input_limit_resistor_pin   = reg_write && (reg_addr == CCSS_ADDR_INPUT_LIMIT_RESISTOR_PIN);
  wire logic wr_ichg   = reg_write && (reg_addr == CCSS_ADDR_ICHG);
  wire logic wr_irq    = reg_write && (reg_addr == CCSS_ADDR_IRQ);
  wire logic wr_mask   = reg_write && (reg_addr == CCSS_ADDR_MASK);
  wire logic access    = reg_write || reg_read;
  wire logic wdog_en   = ctrl_ff[CCSS_CTRL_WDOG_EN];
  wire logic wdog_hit  = wdog_en && (wdog_ff == 32'h0) &&
                         (mode_ff == CCSS_HOST);
  wire logic pg_rise   = power_good && !pg_ff;

  ////////////////////////////////////////////////////////////////////////
  // Pin decode and charge sequencing
  logic [11:0]    pin_input_limit_resistor_pin;
  logic [9:0]     pin_floor;
  logic           pin_hiz;
  logic           phase_change;
  ccss_phase_type phase;
  wire logic [11:0] ext_input_limit_resistor_pin;
  wire logic [9:0]  ext_floor;
  // A shorted limit pin selects the internal 2 A default     [R13]
  assign ext_input_limit_resistor_pin  = input_limit_shorted ? CCSS_INPUT_LIMIT_RESISTOR_PIN_2000_MA
                                         : input_limit_resistor_pin;
  assign ext_floor = input_floor_shorted ? CCSS_FLOOR_468
                                         : input_floor_resistor_pin;

  ccss_pin_decode u_dec
  (
    .limit_select_bit0 (limit_select_bit0),
    .limit_select_bit1 (limit_select_bit1),
    .limit_select_bit2 (limit_select_bit2),
    .ext_input_limit_resistor_pin          (ext_input_limit_resistor_pin),
    .ext_floor         (ext_floor),
    .pin_input_limit_resistor_pin          (pin_input_limit_resistor_pin),
    .pin_floor         (pin_floor),
    .pin_hiz           (pin_hiz),
    .usb3_profile      (usb3_profile)
  );

  // Charging holds off while the charge resistor is shorted    [R14]
  ccss_phase_seq u_seq
  (
    .sys_clk       (sys_clk),
    .nrst          (nrst),
    .charge_ok     (power_good && !fault_ff),
    .above_trickle (above_trickle),
    .above_pre     (above_pre),
    .at_regulation (at_regulation),
    .taper_done    (taper_done),
    .phase         (phase),
    .phase_change  (phase_change)
  );
  assign charge_phase = phase; // [R15]

  ////////////////////////////////////////////////////////////////////////
  // Mode decision: host only while commanded, watchdog alive, no DCP
  always_comb
  begin
    nxt_mode = mode_ff;
    if (dcp_present || !power_good)
      nxt_mode = CCSS_STANDALONE;                    // [R3]
    else if (wdog_hit)
      nxt_mode = CCSS_STANDALONE;                    // [R4] [R5]
    else if (pg_rise)
      nxt_mode = (cmd_seen_ff || access) ? CCSS_HOST
                                         : CCSS_STANDALONE; // [R6]
    else if (access && power_good)
      nxt_mode = CCSS_HOST;                          // [R4]
  end

  // Decision is a flop so pin changes are seen on the clock   [R16]
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      mode_ff <= CCSS_STANDALONE;
    else
      mode_ff <= nxt_mode;
  end

  // Remembers any bus command since reset or the last watchdog expiry for the power-good check
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd_seen_ff <= 1'b0;
      pg_ff       <= 1'b0;
    end
    else
    begin
      cmd_seen_ff <= (cmd_seen_ff || access) && !wdog_hit;
      pg_ff       <= power_good;
    end
  end

  // Watchdog reloads on every access; counts only in host mode
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      wdog_ff <= 32'h0;
    else if (access || mode_ff != CCSS_HOST)
      wdog_ff <= 32'(WDOG_CYCLES - 1);
    else if (wdog_ff != 32'h0)
      wdog_ff <= wdog_ff - 32'h1;
  end

  // Charge resistor short is registered as a fault, cleared when the short goes  [R14]
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      fault_ff <= 1'b0;
    else
      fault_ff <= charge_current_shorted;
  end

  ////////////////////////////////////////////////////////////////////////
  // Output selection
  wire logic        host_sel  = (mode_ff == CCSS_HOST);
  wire logic [11:0] sa_input_limit_resistor_pin   = HAS_PINS ? pin_input_limit_resistor_pin : port_detect_input_limit_resistor_pin; // [R11]
  // Host may set the limit only when data-line detection unused [R12]
  wire logic        host_lim  = host_sel && !dpdm_used;
  assign input_limit  = host_lim ? host_input_limit_resistor_pin_ff : sa_input_limit_resistor_pin;      // [R1] [R2]
  assign charge_limit = host_sel ? host_ichg_ff
                                 : charge_current_resistor_pin; // [R1] [R2]
  assign input_voltage_floor = pin_floor;                       // [R9]
  assign input_hiz    = HAS_PINS && pin_hiz && !host_lim;
  assign host_mode    = host_sel;
  assign charge_fault = fault_ff;

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers written by the host                [R1]
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_ff      <= 2'h1;
      host_input_limit_resistor_pin_ff <= CCSS_INPUT_LIMIT_RESISTOR_PIN_500_MA;
      host_ichg_ff <= 12'h1F4;
      mask_ff      <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_ff <= reg_wdata[1:0];
      if (wr_input_limit_resistor_pin)
        host_input_limit_resistor_pin_ff <= reg_wdata[11:0];
      if (wr_ichg)
        host_ichg_ff <= reg_wdata[11:0];
      if (wr_mask)
        mask_ff <= reg_wdata[CCSS_IRQ_W-1:0];
    end
  end

  // Sticky events; a new event wins over a write-one clear
  wire logic [CCSS_IRQ_W-1:0] irq_set = {phase_change,
                                         charge_current_shorted && !fault_ff,
                                         wdog_hit};
  wire logic [CCSS_IRQ_W-1:0] irq_clr = wr_irq ? reg_wdata[CCSS_IRQ_W-1:0]
                                               : '0;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      irq_ff <= '0;
    else
      irq_ff <= (irq_ff & ~irq_clr) | irq_set;
  end
  assign irq = |(irq_ff & mask_ff);

  // Status readback                                           [R1]
  wire logic [31:0] status_word = {19'h0, phase, usb3_profile, pin_hiz,
                                   fault_ff, host_sel, cmd_seen_ff,
                                   power_good, dcp_present, wdog_en,
                                   charge_current_shorted, input_limit_shorted};
  wire logic [31:0] rd_mux =
    (reg_addr == CCSS_ADDR_CTRL)   ? {30'h0, ctrl_ff} :
    (reg_addr == CCSS_ADDR_INPUT_LIMIT_RESISTOR_PIN)   ? {20'h0, host_input_limit_resistor_pin_ff} :
    (reg_addr == CCSS_ADDR_ICHG)   ? {20'h0, host_ichg_ff} :
    (reg_addr == CCSS_ADDR_STATUS) ? status_word :
    (reg_addr == CCSS_ADDR_IRQ)    ? {29'h0, irq_ff} :
    (reg_addr == CCSS_ADDR_MASK)   ? {29'h0, mask_ff} : 32'h0;

  // Read data stand one cycle after the strobe only
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rdata_ff <= 32'h0;
    else
      rdata_ff <= reg_read ? rd_mux : 32'h0;
  end
  assign reg_rdata = rdata_ff;
endmodule

// [ccss_checker.sv]
// Checker for the charger configuration source selector.
// Assumes it is bound to ccss_top and sees only that module's ports.
`timescale 1ns/1ps
module ccss_checker
  import ccss_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // Register port
  input wire logic        reg_write,
  input wire logic        reg_read,
  // Pins and sensing
  input wire logic        limit_select_bit0,
  input wire logic        limit_select_bit1,
  input wire logic        limit_select_bit2,
  input wire logic        input_limit_shorted,
  input wire logic [9:0]  input_floor_resistor_pin,
  input wire logic        input_floor_shorted,
  input wire logic        charge_current_shorted,
  input wire logic        power_good,
  input wire logic        dcp_present,
  input wire logic        dpdm_used,
  // Results
  input wire logic [11:0] input_limit,
  input wire logic [9:0]  input_voltage_floor,
  input wire logic        input_hiz,
  input wire logic        usb3_profile,
  input wire logic        host_mode,
  input wire logic        charge_fault
);
  ////////////////////////////////////////////////////////////////////////////
  // Select code gathered into one field
  wire [2:0] sel;
  assign sel = {limit_select_bit2, limit_select_bit1, limit_select_bit0};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Pin decode, combinational, so checked in the same cycle
  // A host-programmed limit overrides the high-impedance code
  property p_hiz;
    (input_hiz == (sel[1:0] == 2'h3 && !(host_mode && !dpdm_used))) &&
      (!input_hiz || input_voltage_floor == 10'h0);
  endproperty
  a_hiz: assert property (p_hiz) else $error("high-z decode wrong");
  property p_fixed;
    !sel[0] |-> input_voltage_floor == CCSS_FLOOR_436;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed floor wrong");
  property p_ext;
    sel[1:0] == 2'h1 && !input_floor_shorted
      |-> input_voltage_floor == input_floor_resistor_pin;
  endproperty
  a_ext: assert property (p_ext) else $error("external floor wrong");
  property p_usb3;
    usb3_profile == limit_select_bit2;
  endproperty
  a_usb3: assert property (p_usb3) else $error("profile wrong");
  property p_low;
    !host_mode && sel == 3'h0 |-> input_limit == CCSS_INPUT_LIMIT_RESISTOR_PIN_500_MA;
  endproperty
  a_low: assert property (p_low) else $error("500 mA code wrong");
  property p_high;
    !host_mode && sel == 3'h6 |-> input_limit == CCSS_INPUT_LIMIT_RESISTOR_PIN_150_MA;
  endproperty
  a_high: assert property (p_high) else $error("150 mA code wrong");
  property p_short;
    !host_mode && sel[1:0] == 2'h1 && input_limit_shorted
      |-> input_limit == CCSS_INPUT_LIMIT_RESISTOR_PIN_2000_MA;
  endproperty
  a_short: assert property (p_short) else $error("2 A default wrong");
  // Mode and fault are registered, so seen one cycle after the cause
  property p_fault;
    $rose(charge_current_shorted) |=> charge_fault;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not raised");
  property p_dcp;
    dcp_present |=> !host_mode;
  endproperty
  a_dcp: assert property (p_dcp) else $error("host mode with adapter");
  property p_access;
    (reg_write || reg_read) && power_good && !dcp_present |=> host_mode;
  endproperty
  a_access: assert property (p_access) else $error("no host mode");
endmodule

bind ccss_top ccss_checker ccss_checker_i
(
  .sys_clk, .nrst, .reg_write, .reg_read, .limit_select_bit0,
  .limit_select_bit1, .limit_select_bit2, .input_limit_shorted,
  .input_floor_resistor_pin, .input_floor_shorted, .charge_current_shorted,
  .power_good, .dcp_present, .dpdm_used, .input_limit, .input_voltage_floor,
  .input_hiz, .usb3_profile, .host_mode, .charge_fault
);

// [ccss_host_model.sv]
// Host side model: single-cycle register writes and reads.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
module ccss_host_model
(
  // Clock
  input  wire logic        sys_clk,
  // Register port
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  output logic             reg_write,
  output logic             reg_read,
  input  wire logic [31:0] reg_rdata
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero, strobes low
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // One write cycle; data inverted after release so stale values show
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // One read cycle; data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

// [ccss_top_tb.sv]
// Testbench for the source selector: reset, pins, host, watchdog, phases.
// Assumes the host model drives the register port; pins driven here.
`timescale 1ns/1ps
module ccss_top_tb;
  import ccss_pkg::*;
  logic           sys_clk = 1'b0;
  logic           nrst = 1'b0;
  logic [7:0]     reg_addr;
  logic [31:0]    reg_wdata, reg_rdata, rv;
  logic           reg_write, reg_read, hiz, usb3, host, fault, irq;
  logic [2:0]     sel = 3'h0;
  logic           input_limit_resistor_pin_sh = 1'b0, ichg_sh = 1'b0, floor_sh = 1'b0;
  logic           pg = 1'b0, dcp = 1'b0, dpdm = 1'b1;
  logic [3:0]     lvl = 4'h0;
  logic [11:0]    lim, chg;
  logic [9:0]     floor;
  ccss_phase_type phase;
  int             fail_count = 0, check_count = 0, cycles = 0;
  logic [11:0]    exp_lim [0:7] = '{12'h1F4, 12'h2EE, 12'h064, 12'h000,
                                    12'h384, 12'h2EE, 12'h096, 12'h000};
  logic [7:0]     ra [0:4] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18};
  logic [31:0]    rx [0:4] = '{32'h1, 32'h1F4, 32'h1F4, 32'h0, 32'h0};
  ////////////////////////////////////////////////////////////////////////////
  // Clock; hang guard well above the expected 150 or so cycles
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      $display("FAIL at %0t: timeout", $time);
      close_out();
    end
  end
  ccss_host_model ccss_host_model_i (.sys_clk, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata);
  ccss_top #(.WDOG_CYCLES(20)) ccss_top_i (.sys_clk, .nrst, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .limit_select_bit0(sel[0]),
    .limit_select_bit1(sel[1]), .limit_select_bit2(sel[2]),
    .input_limit_resistor_pin(12'h2EE), .input_limit_shorted(input_limit_resistor_pin_sh),
    .charge_current_resistor_pin(12'h320), .charge_current_shorted(ichg_sh),
    .input_floor_resistor_pin(10'h1F4), .input_floor_shorted(floor_sh),
    .power_good(pg), .dcp_present(dcp), .dpdm_used(dpdm),
    .port_detect_input_limit_resistor_pin(12'h0), .above_trickle(lvl[3]), .above_pre(lvl[2]),
    .at_regulation(lvl[1]), .taper_done(lvl[0]), .input_limit(lim),
    .charge_limit(chg), .input_voltage_floor(floor), .input_hiz(hiz),
    .usb3_profile(usb3), .host_mode(host), .charge_fault(fault),
    .charge_phase(phase), .irq);
  ////////////////////////////////////////////////////////////////////////////
  // Compare, counted; four-state so an unknown matches only an unknown
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Let n edges pass, then sample at the settled falling edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // Bounded wait on the design's own phase output
  task automatic wait_phase(input ccss_phase_type p);
    int n;
    n = 0;
    // Never look at the phase in the time step of the edge
    tick(0);
    while (phase !== p && n < 10)
    begin
      tick(1);
      n++;
    end
    chk({29'h0, phase}, {29'h0, p});
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    tick(0);
    chk({31'h0, host}, 32'h0);
    chk({29'h0, phase}, {29'h0, CCSS_IDLE});
    // Unmapped write must not stick; reads leave standalone unpowered
    ccss_host_model_i.wr(8'h18, 32'hFFFFFFFF);
    for (int i = 0; i < 5; i++)
    begin
      ccss_host_model_i.rd(ra[i], rv);
      chk(rv, rx[i]);
    end
    // Read data stand for one cycle only
    tick(1);
    chk(reg_rdata, 32'h0);
    chk({31'h0, host}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      sel <= 3'(i);
      tick(0);
      chk({20'h0, lim}, {20'h0, exp_lim[i]});
      chk({22'h0, floor}, {22'h0, i[0] ? (i[1] ? 10'h0 : 10'h1F4) : 10'h1B4});
      chk({30'h0, hiz, usb3}, {30'h0, i[1] & i[0], i[2]});
      chk({20'h0, chg}, 32'h320);
    end
    @(posedge sys_clk);
    sel <= 3'h1;
    input_limit_resistor_pin_sh <= 1'b1;
    floor_sh <= 1'b1;
    tick(0);
    chk({20'h0, lim}, 32'h7D0);
    chk({22'h0, floor}, 32'h1D4);
    @(posedge sys_clk);
    sel <= 3'h0;
    input_limit_resistor_pin_sh <= 1'b0;
    floor_sh <= 1'b0;
    pg <= 1'b1;
    dpdm <= 1'b0;
    $display("test pins done");
    // Power good with a command already seen selects the registers
    tick(1);
    chk({31'h0, host}, 32'h1);
    ccss_host_model_i.wr(CCSS_ADDR_INPUT_LIMIT_RESISTOR_PIN, 32'h258);
    ccss_host_model_i.wr(CCSS_ADDR_ICHG, 32'h3E8);
    tick(0);
    chk({31'h0, host}, 32'h1);
    chk({20'h0, lim}, 32'h258);
    @(posedge sys_clk);
    dpdm <= 1'b1;
    tick(0);
    chk({20'h0, lim}, 32'h1F4);
    @(posedge sys_clk);
    dpdm <= 1'b0;
    chk({20'h0, chg}, 32'h3E8);
    ccss_host_model_i.rd(CCSS_ADDR_STATUS, rv);
    chk({30'h0, rv[6], rv[4]}, 32'h3);
    $display("test host done");
    // A set mask bit lets its event through to irq
    ccss_host_model_i.wr(CCSS_ADDR_MASK, 32'h1);
    ccss_host_model_i.wr(CCSS_ADDR_IRQ, 32'h7);
    tick(30);
    chk({30'h0, host, irq}, 32'h1);
    ccss_host_model_i.wr(CCSS_ADDR_MASK, 32'h0);
    tick(0);
    chk({31'h0, irq}, 32'h0);
    ccss_host_model_i.wr(CCSS_ADDR_MASK, 32'h1);
    ccss_host_model_i.wr(CCSS_ADDR_IRQ, 32'h1);
    tick(0);
    chk({31'h0, irq}, 32'h0);
    ccss_host_model_i.wr(CCSS_ADDR_CTRL, 32'h0);
    tick(30);
    chk({31'h0, host}, 32'h1);
    ccss_host_model_i.wr(CCSS_ADDR_CTRL, 32'h1);
    $display("test watchdog done");
    @(posedge sys_clk);
    ichg_sh <= 1'b1;
    tick(2);
    chk({31'h0, fault}, 32'h1);
    ccss_host_model_i.rd(CCSS_ADDR_IRQ, rv);
    chk({31'h0, rv[1]}, 32'h1);
    @(posedge sys_clk);
    ichg_sh <= 1'b0;
    dcp <= 1'b1;
    tick(2);
    chk({31'h0, host}, 32'h0);
    @(posedge sys_clk);
    dcp <= 1'b0;
    $display("test fault done");
    wait_phase(CCSS_TRICKLE);
    for (int i = 3; i >= 0; i--)
    begin
      @(posedge sys_clk);
      lvl[i] <= 1'b1;
      wait_phase(ccss_phase_type'(5 - i));
    end
    $display("test phases done");
    close_out();
  end
endmodule
